// >>> core/cmix_map.svh
`ifndef CMIX_MAP_SVH
`define CMIX_MAP_SVH

// ==========================================================
// Register offsets (index; byte address is four times this)
`define CMIX_IDX_AUX3        4'h6
`define CMIX_IDX_MIC         4'h7
`define CMIX_IDX_MONO        4'h8
`define CMIX_IDX_CTRL        4'h9
`define CMIX_IDX_STATUS      4'ha

// ==========================================================
// Field positions
`define CMIX_LEFT_MUTE_BIT   15
`define CMIX_LEFT_GAIN_LO    8
`define CMIX_RIGHT_MUTE_BIT  7
`define CMIX_RIGHT_GAIN_LO   0
`define CMIX_ALL_MUTE_BIT    7
`define CMIX_MONO_OUT_BIT    6
`define CMIX_HP_MUTE_BIT     5
`define CMIX_HP_SWING_BIT    4
`define CMIX_SUM_MUTE_BIT    3
`define CMIX_DAC2_TIME_BIT   1
`define CMIX_DAC1_TIME_BIT   0
`define CMIX_CTRL_PDN_BIT    0
`define CMIX_CTRL_AAM_BIT    1
`define CMIX_CTRL_ANA_BIT    2

// ==========================================================
// Writable bit masks (reserved bits always read zero)
`define CMIX_MIX_WMASK       16'h9f9f
`define CMIX_MONO_WMASK      16'h9ffb
`define CMIX_CTRL_WMASK      16'h0007

// ==========================================================
// Reset values
`define CMIX_MIX_RESET       16'h8888
`define CMIX_MONO_RESET      16'h8800
`define CMIX_CTRL_RESET      16'h0006

// ==========================================================
// Timing: gain change timeout, 10 ms minimum of the 10 to 12 ms window
`define CMIX_CLK_HZ          125000000
`define CMIX_TIMEOUT_US      10000
`define CMIX_TIMEOUT_CYC     ((`CMIX_CLK_HZ / 1000000) * `CMIX_TIMEOUT_US)

`endif

// >>> core/cmix_pkg.sv
package cmix_pkg;

	typedef struct packed {
		logic       left_mute;
		logic [4:0] left_gain;
		logic       right_mute;
		logic [4:0] right_gain;
	} cmix_path_t;

	typedef struct packed {
		logic       mono_input_mute;
		logic [4:0] mono_input_gain;
		logic       all_mix_mute;
		logic       mono_output_mute;
		logic       headphone_output_mute;
		logic       headphone_swing_select;
		logic       sum_input_mute;
		logic       dac_two_change_timing;
		logic       dac_one_change_timing;
	} cmix_misc_t;

	typedef struct packed {
		logic        cyc;
		logic        stb;
		logic        we;
		logic [3:0]  adr;
		logic [1:0]  sel;
		logic [15:0] dat;
	} cmix_wb_req_t;

	typedef enum logic [1:0] {
		CMIX_IDLE    = 2'b00,
		CMIX_PENDING = 2'b01,
		CMIX_APPLY   = 2'b10
	} cmix_gain_state_t;

endpackage : cmix_pkg

// >>> core/cmix_regs.sv
// Added by the designer: the Wishbone register port.
`timescale 1ns/1ps
`include "cmix_map.svh"

// Operation
// - Aux-3 register: left mute 15, left gain 12:8, right mute 7, right gain 4:0.
// - Mix mute bit 0 enables its path, 1 mutes it.
// - Gain codes step -1.5 dB per LSB; 00000 +12 dB, 01000 0 dB, 11111 -34.5 dB.
// - Aux-3 and microphone registers reset to 8888 hex.
// - Reset pin or power-down pin low holds them at default, ignoring writes.
// - Conversion power-down bit at 1 holds them at default, ignoring writes.
// - Analog-to-mix or analog-channel enable at 0 holds them at default.
// - Microphone register uses the same layout as aux-3.
// - Address 8 high byte: mono input mute 15, mono gain 12:8.
// - Timing bit 1 applies gain now; 0 waits for zero crossing or 10 ms timeout.
// - All-mix mute mutes every mix path into DAC1 regardless of own bits.
module cmix_regs
	import cmix_pkg::*;
#(
	parameter int unsigned TIMEOUT_CYC = `CMIX_TIMEOUT_CYC
) (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        reset_pin_n_i,
	input  wire logic        power_down_pin_n_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [5:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	input  wire logic        dac1_zero_cross_i,
	input  wire logic        dac2_zero_cross_i,
	input  wire logic        dac1_gain_change_i,
	input  wire logic        dac2_gain_change_i,
	output logic             dac1_gain_apply_o,
	output logic             dac2_gain_apply_o,
	output cmix_path_t       aux_three_eff_o,
	output cmix_path_t       microphone_eff_o,
	output cmix_misc_t       misc_eff_o
);

	// ==========================================================
	// Pin synchronisers
	logic [1:0] reset_pin_sync;
	logic [1:0] pdn_pin_sync;
	logic [1:0] zc1_sync;
	logic [1:0] zc2_sync;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			reset_pin_sync <= 2'b00;
			pdn_pin_sync   <= 2'b00;
			zc1_sync       <= 2'b00;
			zc2_sync       <= 2'b00;
		end else begin
			reset_pin_sync <= {reset_pin_sync[0], reset_pin_n_i};
			pdn_pin_sync   <= {pdn_pin_sync[0], power_down_pin_n_i};
			zc1_sync       <= {zc1_sync[0], dac1_zero_cross_i};
			zc2_sync       <= {zc2_sync[0], dac2_zero_cross_i};
		end
	end

	// ==========================================================
	// Register storage
	logic [15:0]  aux_three_mix_control;
	logic [15:0]  microphone_mix_control;
	logic [15:0]  mono_mix_and_misc_control;
	logic [15:0]  codec_enable_control;
	logic         hold_default;
	cmix_wb_req_t req;
	logic         wr_en;

	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] nv,
		input logic [1:0] sel, input logic [15:0] mask);
		logic [15:0] m;
		m = {{8{sel[1]}}, {8{sel[0]}}} & mask;
		merge16 = (old & ~m) | (nv & m);
	endfunction : merge16

	assign req.cyc = wb_cyc_i;
	assign req.stb = wb_stb_i;
	assign req.we  = wb_we_i;
	assign req.adr = wb_adr_i[5:2];
	assign req.sel = wb_sel_i[1:0];
	assign req.dat = wb_dat_i[15:0];
	assign wr_en   = req.cyc && req.stb && req.we && !wb_ack_o;

	// Pin holds are seen through the synchroniser, so they act two cycles late
	assign hold_default = !reset_pin_sync[1] || !pdn_pin_sync[1]
		|| codec_enable_control[`CMIX_CTRL_PDN_BIT]
		|| !codec_enable_control[`CMIX_CTRL_AAM_BIT]
		|| !codec_enable_control[`CMIX_CTRL_ANA_BIT];

	// Reserved bits are masked off; the host is expected to write them as zero anyway
	always_ff @(posedge clk_i) begin
		if (rst_i || hold_default) begin
			aux_three_mix_control  <= `CMIX_MIX_RESET;
			microphone_mix_control <= `CMIX_MIX_RESET;
		end else if (wr_en) begin
			if (req.adr == `CMIX_IDX_AUX3)
				aux_three_mix_control <= merge16(aux_three_mix_control, req.dat,
					req.sel, `CMIX_MIX_WMASK);
			if (req.adr == `CMIX_IDX_MIC)
				microphone_mix_control <= merge16(microphone_mix_control, req.dat,
					req.sel, `CMIX_MIX_WMASK);
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i || !reset_pin_sync[1] || !pdn_pin_sync[1]) begin
			mono_mix_and_misc_control <= `CMIX_MONO_RESET;
		end else if (wr_en && req.adr == `CMIX_IDX_MONO) begin
			mono_mix_and_misc_control <= merge16(mono_mix_and_misc_control, req.dat,
				req.sel, `CMIX_MONO_WMASK);
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			codec_enable_control <= `CMIX_CTRL_RESET;
		end else if (wr_en && req.adr == `CMIX_IDX_CTRL) begin
			codec_enable_control <= merge16(codec_enable_control, req.dat,
				req.sel, `CMIX_CTRL_WMASK);
		end
	end

	// ==========================================================
	// Wishbone answer: one wait state (ack registered the cycle after the strobe), ack drops after one cycle
	logic [15:0] rd_word;

	always_comb begin
		case (req.adr)
			`CMIX_IDX_AUX3:   rd_word = aux_three_mix_control;
			`CMIX_IDX_MIC:    rd_word = microphone_mix_control;
			`CMIX_IDX_MONO:   rd_word = mono_mix_and_misc_control;
			`CMIX_IDX_CTRL:   rd_word = codec_enable_control;
			`CMIX_IDX_STATUS: rd_word = {13'h0000, hold_default, dac2_gain_apply_o, dac1_gain_apply_o};
			default:          rd_word = 16'h0000;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= req.cyc && req.stb && !wb_ack_o;
			wb_dat_o <= {16'h0000, rd_word};
		end
	end

	// ==========================================================
	// Effective mix settings
	function automatic cmix_path_t to_path(input logic [15:0] r, input logic all_mute);
		cmix_path_t p;
		p.left_mute  = r[`CMIX_LEFT_MUTE_BIT] | all_mute;
		p.left_gain  = r[`CMIX_LEFT_GAIN_LO +: 5];
		p.right_mute = r[`CMIX_RIGHT_MUTE_BIT] | all_mute;
		p.right_gain = r[`CMIX_RIGHT_GAIN_LO +: 5];
		to_path = p;
	endfunction : to_path

	logic all_mute;
	assign all_mute = mono_mix_and_misc_control[`CMIX_ALL_MUTE_BIT];

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			aux_three_eff_o  <= to_path(`CMIX_MIX_RESET, 1'b0);
			microphone_eff_o <= to_path(`CMIX_MIX_RESET, 1'b0);
			misc_eff_o       <= '0;
		end else begin
			aux_three_eff_o  <= to_path(aux_three_mix_control, all_mute);
			microphone_eff_o <= to_path(microphone_mix_control, all_mute);
			misc_eff_o.mono_input_mute        <= mono_mix_and_misc_control[15] | all_mute;
			misc_eff_o.mono_input_gain        <= mono_mix_and_misc_control[12:8];
			misc_eff_o.all_mix_mute           <= all_mute;
			misc_eff_o.mono_output_mute       <= mono_mix_and_misc_control[`CMIX_MONO_OUT_BIT];
			misc_eff_o.headphone_output_mute  <= mono_mix_and_misc_control[`CMIX_HP_MUTE_BIT];
			misc_eff_o.headphone_swing_select <= mono_mix_and_misc_control[`CMIX_HP_SWING_BIT];
			misc_eff_o.sum_input_mute         <= mono_mix_and_misc_control[`CMIX_SUM_MUTE_BIT] | all_mute;
			misc_eff_o.dac_two_change_timing  <= mono_mix_and_misc_control[`CMIX_DAC2_TIME_BIT];
			misc_eff_o.dac_one_change_timing  <= mono_mix_and_misc_control[`CMIX_DAC1_TIME_BIT];
		end
	end

	// ==========================================================
	// DAC gain change timing, one engine per DAC
	logic [1:0] change_req;
	logic [1:0] zc_now;
	logic [1:0] immediate;
	logic [1:0] apply;
	logic [1:0] zc_prev;

	assign change_req = {dac2_gain_change_i, dac1_gain_change_i};
	assign immediate  = {mono_mix_and_misc_control[`CMIX_DAC2_TIME_BIT],
		mono_mix_and_misc_control[`CMIX_DAC1_TIME_BIT]};

	always_ff @(posedge clk_i) begin
		if (rst_i)
			zc_prev <= 2'b00;
		else
			zc_prev <= {zc2_sync[1], zc1_sync[1]};
	end

	// A midscale crossing is taken as a rising edge of the crossing flag
	assign zc_now = {zc2_sync[1], zc1_sync[1]} & ~zc_prev;

	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : gen_dac
			cmix_gain_state_t state;
			logic [23:0]      timer;

			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					state <= CMIX_IDLE;
					timer <= 24'h000000;
				end else begin
					case (state)
						CMIX_IDLE: begin
							timer <= 24'h000000;
							if (change_req[g])
								state <= immediate[g] ? CMIX_APPLY : CMIX_PENDING;
						end
						CMIX_PENDING: begin
							timer <= timer + 24'h000001;
							if (immediate[g] || zc_now[g] || timer >= 24'(TIMEOUT_CYC - 1))
								state <= CMIX_APPLY;
						end
						CMIX_APPLY: begin
							state <= CMIX_IDLE;
						end
						default: state <= CMIX_IDLE;
					endcase
				end
			end

			assign apply[g] = (state == CMIX_APPLY);

			AST_TIMEOUT_BOUND: assert property (@(posedge clk_i) disable iff (rst_i)
				state == CMIX_PENDING |-> timer < 24'(TIMEOUT_CYC))
				else $error("Gain change waited past timeout");
		end
	endgenerate

	assign dac1_gain_apply_o = apply[0];
	assign dac2_gain_apply_o = apply[1];

	// ==========================================================
	// Checks
	AST_HOLD_DEFAULT: assert property (@(posedge clk_i) disable iff (rst_i)
		$past(hold_default) |-> aux_three_mix_control == `CMIX_MIX_RESET)
		else $error("Aux-3 register not at default while held");

	AST_HOLD_MIC: assert property (@(posedge clk_i) disable iff (rst_i)
		$past(codec_enable_control[`CMIX_CTRL_PDN_BIT]) |-> microphone_mix_control == `CMIX_MIX_RESET)
		else $error("Mic register not at default under power-down bit");

	AST_ENABLE_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
		!$past(codec_enable_control[`CMIX_CTRL_AAM_BIT]) |-> aux_three_mix_control == `CMIX_MIX_RESET)
		else $error("Aux-3 register not at default with mix disabled");

	AST_MIC_PIN_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
		$past(!reset_pin_sync[1] || !pdn_pin_sync[1]) |-> microphone_mix_control == `CMIX_MIX_RESET)
		else $error("Mic register not at default while a pin is low");

	AST_MIC_ENABLE_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
		!$past(codec_enable_control[`CMIX_CTRL_ANA_BIT]) |-> microphone_mix_control == `CMIX_MIX_RESET)
		else $error("Mic register not at default with analog channels off");

	AST_AUX_PDN_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
		$past(codec_enable_control[`CMIX_CTRL_PDN_BIT]) |-> aux_three_mix_control == `CMIX_MIX_RESET)
		else $error("Aux-3 register not at default under power-down bit");

	AST_RESERVED_ZERO: assert property (@(posedge clk_i) disable iff (rst_i)
		(aux_three_mix_control & ~`CMIX_MIX_WMASK) == 16'h0000
		&& (mono_mix_and_misc_control & ~`CMIX_MONO_WMASK) == 16'h0000)
		else $error("Reserved bit set");

	AST_MIC_RESERVED: assert property (@(posedge clk_i) disable iff (rst_i)
		(microphone_mix_control & ~`CMIX_MIX_WMASK) == 16'h0000)
		else $error("Mic reserved bit set");

	AST_AUX_WRITE: assert property (@(posedge clk_i) disable iff (rst_i)
		wr_en && req.adr == `CMIX_IDX_AUX3 && req.sel == 2'b11 && !hold_default
		|=> aux_three_mix_control == ($past(req.dat) & `CMIX_MIX_WMASK))
		else $error("Aux-3 write not stored");

	AST_MIC_WRITE: assert property (@(posedge clk_i) disable iff (rst_i)
		wr_en && req.adr == `CMIX_IDX_MIC && req.sel == 2'b11 && !hold_default
		|=> microphone_mix_control == ($past(req.dat) & `CMIX_MIX_WMASK))
		else $error("Mic write not stored");

	AST_MONO_WRITE: assert property (@(posedge clk_i) disable iff (rst_i)
		wr_en && req.adr == `CMIX_IDX_MONO && req.sel == 2'b11 && reset_pin_sync[1] && pdn_pin_sync[1]
		|=> mono_mix_and_misc_control == ($past(req.dat) & `CMIX_MONO_WMASK))
		else $error("Mono write not stored");

	AST_ALL_MUTE: assert property (@(posedge clk_i) disable iff (rst_i)
		$past(all_mute) |-> aux_three_eff_o.left_mute && microphone_eff_o.right_mute
		&& misc_eff_o.mono_input_mute)
		else $error("All-mix mute not applied");

	AST_ALL_MUTE_REST: assert property (@(posedge clk_i) disable iff (rst_i)
		$past(all_mute) |-> aux_three_eff_o.right_mute && microphone_eff_o.left_mute
		&& misc_eff_o.sum_input_mute && misc_eff_o.all_mix_mute)
		else $error("All-mix mute missed a path");

	AST_MUTE_PASS: assert property (@(posedge clk_i) disable iff (rst_i)
		!$past(all_mute) |-> aux_three_eff_o.right_mute == $past(aux_three_mix_control[`CMIX_RIGHT_MUTE_BIT])
		&& aux_three_eff_o.left_gain == $past(aux_three_mix_control[`CMIX_LEFT_GAIN_LO +: 5]))
		else $error("Mix mute or gain not passed through");

	AST_MIC_PASS: assert property (@(posedge clk_i) disable iff (rst_i)
		!$past(all_mute) |-> microphone_eff_o.left_mute == $past(microphone_mix_control[`CMIX_LEFT_MUTE_BIT])
		&& microphone_eff_o.right_gain == $past(microphone_mix_control[`CMIX_RIGHT_GAIN_LO +: 5]))
		else $error("Mic mute or gain not passed through");

	AST_MONO_PASS: assert property (@(posedge clk_i) disable iff (rst_i)
		!$past(rst_i) && !$past(all_mute) |-> misc_eff_o.mono_input_mute == $past(mono_mix_and_misc_control[15])
		&& misc_eff_o.mono_input_gain == $past(mono_mix_and_misc_control[12:8]))
		else $error("Mono input mute or gain not passed through");

	AST_MISC_BITS: assert property (@(posedge clk_i) disable iff (rst_i)
		!$past(rst_i) |-> misc_eff_o.mono_output_mute == $past(mono_mix_and_misc_control[`CMIX_MONO_OUT_BIT])
		&& misc_eff_o.headphone_output_mute == $past(mono_mix_and_misc_control[`CMIX_HP_MUTE_BIT])
		&& misc_eff_o.headphone_swing_select == $past(mono_mix_and_misc_control[`CMIX_HP_SWING_BIT])
		&& misc_eff_o.dac_one_change_timing == $past(mono_mix_and_misc_control[`CMIX_DAC1_TIME_BIT]))
		else $error("Output setting bit not passed through");

	AST_IMMEDIATE: assert property (@(posedge clk_i) disable iff (rst_i)
		gen_dac[0].state == CMIX_IDLE && change_req[0] && immediate[0]
		|=> dac1_gain_apply_o ##1 !dac1_gain_apply_o)
		else $error("Immediate gain change not applied next cycle");

	AST_IMMEDIATE_TWO: assert property (@(posedge clk_i) disable iff (rst_i)
		gen_dac[1].state == CMIX_IDLE && change_req[1] && immediate[1]
		|=> dac2_gain_apply_o ##1 !dac2_gain_apply_o)
		else $error("Immediate DAC2 gain change not applied next cycle");

	AST_ZC_APPLY: assert property (@(posedge clk_i) disable iff (rst_i)
		gen_dac[0].state == CMIX_PENDING && zc_now[0] |=> dac1_gain_apply_o)
		else $error("Zero crossing did not apply DAC1 gain");

	AST_ZC_APPLY_TWO: assert property (@(posedge clk_i) disable iff (rst_i)
		gen_dac[1].state == CMIX_PENDING && zc_now[1] |=> dac2_gain_apply_o)
		else $error("Zero crossing did not apply DAC2 gain");

	AST_APPLY_PULSE: assert property (@(posedge clk_i) disable iff (rst_i)
		apply != 2'b00 |=> (apply & $past(apply)) == 2'b00)
		else $error("Gain apply held longer than one cycle");

	AST_ACK_AFTER_REQ: assert property (@(posedge clk_i) disable iff (rst_i)
		req.cyc && req.stb && !wb_ack_o |=> wb_ack_o)
		else $error("Request not acknowledged next cycle");

	AST_ACK_PULSE: assert property (@(posedge clk_i) disable iff (rst_i)
		wb_ack_o |=> !wb_ack_o)
		else $error("Ack held longer than one cycle");

endmodule : cmix_regs

// >>> sim/cmix_host.sv
`timescale 1ns/1ps
// ==========================================
// Host model: classic Wishbone master, one request at a time
module cmix_host (
	input  wire logic        clk_i,
	input  wire logic        ack_i,
	input  wire logic [31:0] dat_i,
	output logic             cyc_o,
	output logic             stb_o,
	output logic             we_o,
	output logic [5:0]       adr_o,
	output logic [3:0]       sel_o,
	output logic [31:0]      dat_o
);
	logic [15:0] rdata;
	// Byte lanes of the next request; the bench narrows it for lane tests
	logic [3:0]  lanes;
	initial begin
		lanes = 4'h3;
		cyc_o = 1'b0;
		stb_o = 1'b0;
		we_o = 1'b0;
		adr_o = 6'h00;
		sel_o = 4'h0;
		dat_o = 32'h00000000;
		rdata = 16'h0000;
	end
	// Reserved bits of registers 6 to 9 are sent as zero; other addresses send all bits
	function automatic logic [15:0] keep(input logic [3:0] idx);
		case (idx)
			4'h6, 4'h7: keep = 16'h9f9f;
			4'h8: keep = 16'h9ffb;
			4'h9: keep = 16'h0007;
			default: keep = 16'hffff;
		endcase
	endfunction : keep
	task automatic xfer(input logic w, input logic [3:0] idx, input logic [15:0] d);
		@(posedge clk_i);
		cyc_o <= 1'b1;
		stb_o <= 1'b1;
		we_o <= w;
		adr_o <= {idx, 2'b00};
		sel_o <= lanes;
		dat_o <= {16'h0000, d & keep(idx)};
		do @(posedge clk_i); while (ack_i !== 1'b1);
		rdata = dat_i[15:0];
		cyc_o <= 1'b0;
		stb_o <= 1'b0;
		we_o <= 1'b0;
		// Released data must not look valid
		dat_o <= ~dat_o;
	endtask : xfer
endmodule : cmix_host

// >>> sim/tb.sv
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin miscompares++; $display("Error at %0t: got %h expected %h", $time, (a), (b)); end end
module tb;
	import cmix_pkg::*;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        rpin_n = 1'b1;
	logic        ppin_n = 1'b1;
	logic [1:0]  zc = 2'b00;
	logic [1:0]  chg = 2'b00;
	logic [1:0]  apply;
	logic        cyc, stb, we, ack;
	logic [5:0]  adr;
	logic [3:0]  sel;
	logic [31:0] wdat, rdat;
	cmix_path_t  aux_eff, mic_eff;
	cmix_misc_t  misc_eff;
	int          miscompares = 0;
	int          check_count = 0;
	int          n;
	logic [15:0] v;
	logic [3:0]  idx;
	always #4 clk_i = ~clk_i;
	cmix_host host (.clk_i(clk_i), .ack_i(ack), .dat_i(rdat), .cyc_o(cyc), .stb_o(stb), .we_o(we),
		.adr_o(adr), .sel_o(sel), .dat_o(wdat));
	cmix_regs #(.TIMEOUT_CYC(50)) dut (.clk_i(clk_i), .rst_i(rst_i), .reset_pin_n_i(rpin_n),
		.power_down_pin_n_i(ppin_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .dac1_zero_cross_i(zc[0]),
		.dac2_zero_cross_i(zc[1]), .dac1_gain_change_i(chg[0]), .dac2_gain_change_i(chg[1]),
		.dac1_gain_apply_o(apply[0]), .dac2_gain_apply_o(apply[1]), .aux_three_eff_o(aux_eff),
		.microphone_eff_o(mic_eff), .misc_eff_o(misc_eff));
	// ==========================================
	// Expectations
	function automatic cmix_path_t exp_path(input logic [15:0] r, input logic all);
		exp_path = '{r[15] | all, r[12:8], r[7] | all, r[4:0]};
	endfunction : exp_path
	function automatic cmix_misc_t exp_misc(input logic [15:0] r);
		exp_misc = '{r[15] | r[7], r[12:8], r[7], r[6], r[5], r[4], r[3] | r[7], r[1], r[0]};
	endfunction : exp_misc
	task automatic rd_chk(input logic [3:0] i, input logic [15:0] e);
		host.xfer(1'b0, i, 16'h0000);
		`CHK(host.rdata, e)
	endtask : rd_chk
	task automatic report_and_stop;
		$display("Checks %0d, mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : report_and_stop
	// ==========================================
	// Watchdog: the sequence needs a few hundred cycles
	initial begin
		repeat (20000) @(posedge clk_i);
		miscompares++;
		report_and_stop;
	end
	// ==========================================
	// Tests
	initial begin
		v = 16'($urandom(60));
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (4) @(posedge clk_i);
		rd_chk(4'h6, 16'h8888);
		rd_chk(4'h7, 16'h8888);
		rd_chk(4'h8, 16'h8800);
		rd_chk(4'h9, 16'h0006);
		rd_chk(4'ha, 16'h0000);
		// Corner gain codes first, then random fields
		for (int i = 0; i < 14; i++) begin
			v = (i == 0) ? 16'h0000 : (i == 1) ? 16'h0808 : (i == 2) ? 16'h1f1f : 16'($urandom);
			idx = 4'h6 + 4'(i % 2);
			host.xfer(1'b1, idx, v);
			rd_chk(idx, v & 16'h9f9f);
			repeat (2) @(posedge clk_i);
			`CHK((idx == 4'h6) ? aux_eff : mic_eff, exp_path(v & 16'h9f9f, 1'b0))
		end
		host.xfer(1'b1, 4'h6, 16'h0808);
		// Upper byte lane only: the lower byte must keep its 08
		host.lanes = 4'h2;
		host.xfer(1'b1, 4'h6, 16'h1f1f);
		host.lanes = 4'h3;
		rd_chk(4'h6, 16'h1f08);
		host.xfer(1'b1, 4'h6, 16'h0808);
		for (int i = 0; i < 6; i++) begin
			v = 16'($urandom) & 16'h9ffb;
			v[7] = i[0];
			host.xfer(1'b1, 4'h8, v);
			rd_chk(4'h8, v);
			repeat (2) @(posedge clk_i);
			`CHK(misc_eff, exp_misc(v))
			`CHK(aux_eff, exp_path(16'h0808, v[7]))
		end
		host.xfer(1'b1, 4'h8, 16'h0000);
		// Each hold source in turn
		for (int c = 0; c < 5; c++) begin
			host.xfer(1'b1, 4'h6, 16'h0303);
			if (c < 3)
				host.xfer(1'b1, 4'h9, (c == 0) ? 16'h0007 : (c == 1) ? 16'h0004 : 16'h0002);
			else if (c == 3)
				ppin_n <= 1'b0;
			else
				rpin_n <= 1'b0;
			repeat (4) @(posedge clk_i);
			host.xfer(1'b1, 4'h6, 16'h0101);
			rd_chk(4'h6, 16'h8888);
			rd_chk(4'ha, 16'h0004);
			`CHK(aux_eff, exp_path(16'h8888, 1'b0))
			host.xfer(1'b1, 4'h9, 16'h0006);
			ppin_n <= 1'b1;
			rpin_n <= 1'b1;
			repeat (4) @(posedge clk_i);
		end
		host.xfer(1'b1, 4'hf, 16'hffff);
		rd_chk(4'hf, 16'h0000);
		// Gain change timing: immediate, zero crossing, timeout
		for (int d = 0; d < 2; d++) begin
			for (int m = 0; m < 3; m++) begin
				host.xfer(1'b1, 4'h8, (m == 0) ? ((d == 1) ? 16'h0002 : 16'h0001) : 16'h0000);
				@(posedge clk_i);
				chg[d] <= 1'b1;
				@(posedge clk_i);
				chg[d] <= 1'b0;
				zc[d] <= (m == 1);
				n = 0;
				do begin
					@(posedge clk_i);
					n++;
				end while (apply[d] !== 1'b1 && n < 100);
				if (m == 0)
					`CHK(n, 1)
				else if (m == 1)
					`CHK(n >= 2 && n <= 7, 1'b1)
				else
					`CHK(n >= 50 && n <= 53, 1'b1)
				zc[d] <= 1'b0;
				repeat (3) @(posedge clk_i);
			end
		end
		report_and_stop;
	end
endmodule : tb
